// [amc_pkg.sv]
// package: register map, field layout and timing constants for the converter control block
package amc_pkg;
  localparam logic [7:0] IO_ADDR_RESULT_LOW = 8'h04;
  localparam logic [7:0] IO_ADDR_RESULT_HIGH = 8'h05;
  localparam logic [7:0] IO_ADDR_CTRL_STATUS = 8'h06;
  localparam logic [7:0] IO_ADDR_INPUT_REF = 8'h07;
  localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] INPUT_REF_RESET = 8'h00;
  // control/status bit positions
  localparam int CS_ON_BIT = 7;
  localparam int CS_GO_BIT = 6;
  localparam int CS_FREE_BIT = 5;
  localparam int CS_FLAG_BIT = 4;
  localparam int CS_IRQ_EN_BIT = 3;
  // input/reference select bit positions
  localparam int IR_REF_LSB = 6;
  localparam int IR_ALIGN_BIT = 5;
  localparam int IR_CHAN_LSB = 0;
  // conversion lengths in converter clocks
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0d;
  localparam logic [4:0] CONV_CYCLES_FIRST = 5'h19;
  // reference codes
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  // gain codes
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_10X = 2'h1;
  localparam logic [1:0] GAIN_200X = 2'h2;
  // analog selection sources (pos/neg)
  localparam logic [3:0] SRC_BANDGAP = 4'h8;
  localparam logic [3:0] SRC_GROUND = 4'h9;
  localparam logic [3:0] SRC_NONE = 4'hf;
  typedef enum logic [1:0] {
    AMC_IDLE = 2'b00,
    AMC_CONV = 2'b01,
    AMC_DONE = 2'b11
  } amc_state_t;
endpackage : amc_pkg

// [amc_conv_if.sv]
// interface: conversion request and decoded analog selections between sequencer and analog selection decoder
`timescale 1ns/1ns
interface amc_conv_if;
  logic [4:0] chan;
  logic [1:0] ref_sel;
  logic [3:0] pos_src;
  logic [3:0] neg_src;
  logic [1:0] gain;
  logic diff;
  logic ref_int_on;
  logic ref_supply;
  logic ref_ext;
  modport ctrl (output chan, output ref_sel, input pos_src, input neg_src, input gain, input diff,
    input ref_int_on, input ref_supply, input ref_ext);
  modport dec (input chan, input ref_sel, output pos_src, output neg_src, output gain, output diff,
    output ref_int_on, output ref_supply, output ref_ext);
endinterface : amc_conv_if

// [amc_chan_decode.sv]
// decoder: channel/gain code and reference code to analog switch selections
`timescale 1ns/1ns
module amc_chan_decode (
  amc_conv_if.dec cif
);
  always_comb begin
    cif.pos_src = amc_pkg::SRC_NONE;
    cif.neg_src = amc_pkg::SRC_NONE;
    cif.gain = amc_pkg::GAIN_1X;
    cif.diff = 1'b0;
    if (cif.chan[4:3] == 2'b00) begin
      cif.pos_src = {1'b0, cif.chan[2:0]};
      cif.neg_src = amc_pkg::SRC_GROUND;
    end else if (cif.chan[4:3] == 2'b01) begin
      // pairs 0/1 vs 0 and 2/3 vs 2; even codes short both sides for offset
      cif.diff = 1'b1;
      cif.pos_src = {2'b00, cif.chan[2], cif.chan[0]};
      cif.neg_src = {2'b00, cif.chan[2], 1'b0};
      cif.gain = cif.chan[1] ? amc_pkg::GAIN_200X : amc_pkg::GAIN_10X;
    end else if (cif.chan == 5'h1e) begin
      cif.pos_src = amc_pkg::SRC_BANDGAP;
      cif.neg_src = amc_pkg::SRC_GROUND;
    end else if (cif.chan == 5'h1f) begin
      cif.pos_src = amc_pkg::SRC_GROUND;
      cif.neg_src = amc_pkg::SRC_GROUND;
    end else if (cif.chan[4:3] == 2'b10) begin
      cif.diff = 1'b1;
      cif.pos_src = {1'b0, cif.chan[2:0]};
      cif.neg_src = 4'h1;
    end else begin
      cif.diff = 1'b1;
      cif.pos_src = {1'b0, cif.chan[2:0]};
      cif.neg_src = 4'h2;
    end
  end
  // code 10 is reserved: treated as external pin with internal reference off
  assign cif.ref_int_on = (cif.ref_sel == amc_pkg::REF_INTERNAL);
  assign cif.ref_supply = (cif.ref_sel == amc_pkg::REF_SUPPLY);
  assign cif.ref_ext = ~(cif.ref_int_on | cif.ref_supply);
endmodule : amc_chan_decode

// [amc_clk_div.sv]
// prescaler: one-cycle converter clock ticks from the system clock
`timescale 1ns/1ns
module amc_clk_div (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] last;
  always_comb begin
    // 000 and 001 both divide by two
    last = (sel_i == 3'h0) ? 7'h01 : 7'((8'h01 << sel_i) - 8'h01);
    tick_o = run_i && (cnt_q >= last);
    cnt_d = (!run_i || tick_o) ? 7'h00 : 7'(cnt_q + 7'h01);
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : amc_clk_div

// [amc_top.sv]
// top: converter control/status and input/reference registers, sequencer and result presentation
`timescale 1ns/1ns
module amc_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_data_space_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  input wire logic [9:0] sar_result_i,
  output logic analog_power_o,
  output logic sample_o,
  output logic [3:0] pos_src_o,
  output logic [3:0] neg_src_o,
  output logic [1:0] gain_o,
  output logic diff_o,
  output logic ref_int_on_o,
  output logic ref_supply_o,
  output logic ref_ext_o
);
  logic [7:0] sel_q;
  logic [7:0] sel_d;
  logic on_q;
  logic on_d;
  logic free_q;
  logic free_d;
  logic flag_q;
  logic flag_d;
  logic irq_en_q;
  logic irq_en_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic init_q;
  logic init_d;
  logic [4:0] chan_q;
  logic [4:0] chan_d;
  logic [1:0] ref_q;
  logic [1:0] ref_d;
  logic [4:0] cyc_q;
  logic [4:0] cyc_d;
  logic [4:0] len_q;
  logic [4:0] len_d;
  logic [9:0] res_q;
  logic [9:0] res_d;
  logic lock_q;
  logic lock_d;
  logic pend_q;
  logic pend_d;
  amc_pkg::amc_state_t st_q;
  amc_pkg::amc_state_t st_d;
  logic tick;
  logic [7:0] addr;
  logic hit_cs;
  logic hit_ir;
  logic hit_lo;
  logic hit_hi;
  logic busy;
  logic [15:0] shown;

  amc_conv_if cif ();

  amc_chan_decode u_dec (
    .cif(cif)
  );

  amc_clk_div u_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(busy),
    .sel_i(div_q),
    .tick_o(tick)
  );

  // data-space accesses are shifted down into I/O space
  assign addr = io_data_space_i ? 8'(io_addr_i - amc_pkg::DATA_SPACE_OFFSET) : io_addr_i;
  assign hit_cs = (addr == amc_pkg::IO_ADDR_CTRL_STATUS);
  assign hit_ir = (addr == amc_pkg::IO_ADDR_INPUT_REF);
  assign hit_lo = (addr == amc_pkg::IO_ADDR_RESULT_LOW);
  assign hit_hi = (addr == amc_pkg::IO_ADDR_RESULT_HIGH);
  assign busy = (st_q == amc_pkg::AMC_CONV);

  always_comb begin
    logic go_wr;
    go_wr = 1'b0;
    sel_d = sel_q;
    on_d = on_q;
    free_d = free_q;
    irq_en_d = irq_en_q;
    div_d = div_q;
    init_d = init_q;
    flag_d = flag_q;
    chan_d = chan_q;
    ref_d = ref_q;
    cyc_d = cyc_q;
    len_d = len_q;
    res_d = res_q;
    lock_d = lock_q;
    pend_d = pend_q;
    st_d = st_q;
    if (io_wr_i && hit_ir) begin
      sel_d = io_wdata_i;
    end
    if (io_wr_i && hit_cs) begin
      on_d = io_wdata_i[amc_pkg::CS_ON_BIT];
      free_d = io_wdata_i[amc_pkg::CS_FREE_BIT];
      irq_en_d = io_wdata_i[amc_pkg::CS_IRQ_EN_BIT];
      div_d = io_wdata_i[2:0];
      go_wr = io_wdata_i[amc_pkg::CS_GO_BIT];
      // writing one clears; a completion in the same cycle still sets below
      if (io_wdata_i[amc_pkg::CS_FLAG_BIT]) begin
        flag_d = 1'b0;
      end
      if (!on_q && io_wdata_i[amc_pkg::CS_ON_BIT]) begin
        init_d = 1'b1;
      end
    end
    if (irq_ack_i) begin
      flag_d = 1'b0;
    end
    // low-byte read freezes the result until the high byte is read
    if (io_rd_i && hit_lo) begin
      lock_d = 1'b1;
    end
    if (io_rd_i && hit_hi) begin
      lock_d = 1'b0;
      if (pend_q) begin
        pend_d = 1'b0;
        flag_d = 1'b1;
      end
    end
    case (st_q)
      amc_pkg::AMC_IDLE: begin
        if (go_wr && on_d) begin
          // selections captured here so a conversion never mixes settings
          chan_d = sel_d[4:0];
          ref_d = sel_d[7:6];
          len_d = init_d ? amc_pkg::CONV_CYCLES_FIRST : amc_pkg::CONV_CYCLES_NORMAL;
          init_d = 1'b0;
          cyc_d = 5'h00;
          st_d = amc_pkg::AMC_CONV;
        end
      end
      amc_pkg::AMC_CONV: begin
        if (!on_d) begin
          st_d = amc_pkg::AMC_IDLE;
        end else if (tick) begin
          cyc_d = 5'(cyc_q + 5'h01);
          if (5'(cyc_q + 5'h01) == len_q) begin
            st_d = amc_pkg::AMC_DONE;
          end
        end
      end
      amc_pkg::AMC_DONE: begin
        // a locked result register drops the new value; flag is held back until the high byte is read
        if (!lock_d) begin
          res_d = sar_result_i;
          flag_d = 1'b1;
        end else begin
          pend_d = 1'b1;
        end
        chan_d = sel_d[4:0];
        ref_d = sel_d[7:6];
        cyc_d = 5'h00;
        len_d = amc_pkg::CONV_CYCLES_NORMAL;
        st_d = (free_d && on_d) ? amc_pkg::AMC_CONV : amc_pkg::AMC_IDLE;
      end
      default: begin
        st_d = amc_pkg::AMC_IDLE;
      end
    endcase
    if (!on_d) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_q <= amc_pkg::INPUT_REF_RESET;
      on_q <= 1'b0;
      free_q <= 1'b0;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      div_q <= 3'h0;
      init_q <= 1'b0;
      chan_q <= 5'h00;
      ref_q <= 2'h0;
      cyc_q <= 5'h00;
      len_q <= amc_pkg::CONV_CYCLES_NORMAL;
      res_q <= 10'h000;
      lock_q <= 1'b0;
      pend_q <= 1'b0;
      st_q <= amc_pkg::AMC_IDLE;
    end else begin
      sel_q <= sel_d;
      on_q <= on_d;
      free_q <= free_d;
      flag_q <= flag_d;
      irq_en_q <= irq_en_d;
      div_q <= div_d;
      init_q <= init_d;
      chan_q <= chan_d;
      ref_q <= ref_d;
      cyc_q <= cyc_d;
      len_q <= len_d;
      res_q <= res_d;
      lock_q <= lock_d;
      pend_q <= pend_d;
      st_q <= st_d;
    end
  end

  // alignment follows the live register bit, not the latched one
  assign shown = sel_q[amc_pkg::IR_ALIGN_BIT] ? {res_q, 6'h00} : {6'h00, res_q};

  always_comb begin
    io_rdata_o = 8'h00;
    if (io_rd_i && hit_cs) begin
      io_rdata_o = {on_q, busy || (st_q == amc_pkg::AMC_DONE), free_q, flag_q, irq_en_q, div_q};
    end else if (io_rd_i && hit_ir) begin
      io_rdata_o = sel_q;
    end else if (io_rd_i && hit_lo) begin
      io_rdata_o = shown[7:0];
    end else if (io_rd_i && hit_hi) begin
      io_rdata_o = shown[15:8];
    end
  end

  assign irq_o = flag_q && irq_en_q && global_irq_en_i;
  assign analog_power_o = on_q;
  assign sample_o = busy;
  assign cif.chan = chan_q;
  assign cif.ref_sel = ref_q;
  assign pos_src_o = cif.pos_src;
  assign neg_src_o = cif.neg_src;
  assign gain_o = cif.gain;
  assign diff_o = cif.diff;
  assign ref_int_on_o = cif.ref_int_on;
  assign ref_supply_o = cif.ref_supply;
  assign ref_ext_o = cif.ref_ext;

  a_irq_gating: assert property (@(posedge clk_i) disable iff (!nrst_i)
    irq_o |-> (flag_q && irq_en_q && global_irq_en_i)) else $error("irq without enables");
  a_abort_conv: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (busy && !on_d) |=> (st_q == amc_pkg::AMC_IDLE)) else $error("abort failed");
  a_go_reads_one: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (io_rd_i && hit_cs && busy) |-> io_rdata_o[amc_pkg::CS_GO_BIT]) else $error("go bit low while busy");
  // start from idle with the converter just enabled, or enabled but never started yet
  a_first_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (busy && ($past(st_q) == amc_pkg::AMC_IDLE) && (!$past(on_q) || $past(init_q)))
    |-> (len_q == amc_pkg::CONV_CYCLES_FIRST)) else $error("first length");
  a_normal_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (busy && !$past(busy) && $past(on_q) && !$past(init_q))
    |-> (len_q == amc_pkg::CONV_CYCLES_NORMAL)) else $error("normal length");
  a_flag_done: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == amc_pkg::AMC_DONE && !lock_d) |=> (flag_q && res_q == $past(sar_result_i))) else $error("flag");
  a_ack_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (irq_ack_i && st_q != amc_pkg::AMC_DONE && !(io_rd_i && hit_hi && pend_q)) |=> !flag_q) else $error("ack");
  a_flag_wr_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (io_wr_i && hit_cs && io_wdata_i[amc_pkg::CS_FLAG_BIT] && st_q != amc_pkg::AMC_DONE
      && !(io_rd_i && hit_hi && pend_q)) |=> !flag_q) else $error("flag write clear");
  a_sel_stable: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (busy && $past(busy)) |-> $stable(chan_q) && $stable(ref_q)) else $error("selection moved");
  a_lock_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lock_q && !(io_rd_i && hit_hi)) |=> $stable(res_q)) else $error("result changed while locked");
  a_go_starts: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == amc_pkg::AMC_IDLE && io_wr_i && hit_cs && io_wdata_i[amc_pkg::CS_GO_BIT]
      && io_wdata_i[amc_pkg::CS_ON_BIT]) |=> busy) else $error("start ignored");
  a_zero_go_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == amc_pkg::AMC_IDLE && io_wr_i && hit_cs && !io_wdata_i[amc_pkg::CS_GO_BIT])
    |=> !busy) else $error("zero start acted");
  a_free_again: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_q == amc_pkg::AMC_DONE && free_q && on_q && !(io_wr_i && hit_cs))
    |=> busy) else $error("free run stopped");
  a_align_live: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (io_rd_i && hit_lo && sel_q[amc_pkg::IR_ALIGN_BIT])
    |-> (io_rdata_o == {res_q[1:0], 6'h00})) else $error("left adjust low byte");
endmodule : amc_top

// [amc_analog_model.sv]
// partner: analog front end returning a code built from the selected inputs and gain
`timescale 1ns/1ns
module amc_analog_model (
  input wire logic [3:0] pos_src_i,
  input wire logic [3:0] neg_src_i,
  input wire logic [1:0] gain_i,
  output logic [9:0] result_o
);
  // a distinct code per selection shows which inputs were really latched for the conversion
  assign result_o = {pos_src_i, neg_src_i, gain_i};
endmodule : amc_analog_model

// [tb_adc_mux_and_control.sv]
// bench: registers, conversion timing, selection decode and result presentation
`timescale 1ns/1ns
module tb_adc_mux_and_control;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic io_data_space_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic global_irq_en_i = 1'b0;
  logic irq_ack_i = 1'b0;
  logic [7:0] io_rdata_o, s, lo, hi;
  logic [9:0] sar_result_i;
  logic [3:0] pos_src_o, neg_src_o;
  logic [1:0] gain_o;
  logic irq_o, analog_power_o, sample_o, diff_o, ref_int_on_o, ref_supply_o, ref_ext_o;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  amc_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_data_space_i(io_data_space_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o), .sar_result_i(sar_result_i),
    .analog_power_o(analog_power_o), .sample_o(sample_o), .pos_src_o(pos_src_o), .neg_src_o(neg_src_o),
    .gain_o(gain_o), .diff_o(diff_o), .ref_int_on_o(ref_int_on_o), .ref_supply_o(ref_supply_o),
    .ref_ext_o(ref_ext_o));
  amc_analog_model u_ana (.pos_src_i(pos_src_o), .neg_src_i(neg_src_o), .gain_i(gain_o),
    .result_o(sar_result_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // addresses with bit 5 set are the data-space aliases
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_addr_i <= a;
    io_data_space_i <= a[5];
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    io_addr_i <= a;
    io_data_space_i <= a[5];
    io_rd_i <= 1'b1;
    #1;
    d = io_rdata_o;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1;
  endtask : rd
  // busy window in clocks; slack of two covers the write edge and the done cycle
  task automatic wait_conv(input int exp);
    int n;
    n = 0;
    while (sample_o === 1'b1 && n < 5000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(16'(n >= exp - 2 && n <= exp + 2), 16'h0001);
  endtask : wait_conv
  task automatic run_conv(input logic [7:0] cs, input int exp);
    wr(8'h06, cs);
    wait_conv(exp);
    rd(8'h06, s);
    chk(sample_o, 1'b0);
    chk(s[6], 1'b0);
    chk(s[4], 1'b1);
  endtask : run_conv
  task automatic t_reset();
    chk({ref_int_on_o, ref_supply_o, ref_ext_o}, 3'h1);
    rd(8'h06, s);
    chk(s, 8'h00);
    rd(8'h27, s);
    chk(s, 8'h00);
    wr(8'h08, 8'hff);
    wr(8'h27, 8'h4f);
    rd(8'h07, s);
    chk(s, 8'h4f);
    rd(8'h08, s);
    chk(s, 8'h00);
  endtask : t_reset
  task automatic t_first();
    run_conv(8'hc0, 50);
    for (int k = 0; k < 8; k++) begin
      run_conv(8'hd0 | 8'(k), (k == 0) ? 26 : (13 << k));
    end
  endtask : t_first
  task automatic t_sel(input logic [7:0] mx, input logic [3:0] p, input logic [3:0] n, input logic [1:0] g,
    input logic [2:0] r);
    wr(8'h07, mx & 8'hdf);
    run_conv(8'hd1, 26);
    chk(pos_src_o, p);
    chk(neg_src_o, n);
    chk(gain_o, g);
    chk(diff_o, n != 4'h9);
    chk({ref_int_on_o, ref_supply_o, ref_ext_o}, r);
    rd(8'h04, lo);
    rd(8'h05, hi);
    chk({hi, lo}, {6'h00, p, n, g});
    // alignment flips while the next conversion is still running
    wr(8'h06, 8'hd1);
    wr(8'h07, mx | 8'h20);
    rd(8'h24, lo);
    rd(8'h25, hi);
    chk({hi, lo}, {p, n, g, 6'h00});
    wait_conv(20);
  endtask : t_sel
  task automatic t_mux();
    t_sel(8'h00, 4'h0, 4'h9, 2'h0, 3'h1);
    t_sel(8'h47, 4'h7, 4'h9, 2'h0, 3'h2);
    // nothing drives the reference pin here, so the internal reference is allowed
    t_sel(8'hc8, 4'h0, 4'h0, 2'h1, 3'h4);
    t_sel(8'h8a, 4'h0, 4'h0, 2'h2, 3'h1);
    t_sel(8'h0d, 4'h3, 4'h2, 2'h1, 3'h1);
    t_sel(8'h0f, 4'h3, 4'h2, 2'h2, 3'h1);
    t_sel(8'h10, 4'h0, 4'h1, 2'h0, 3'h1);
    t_sel(8'h1d, 4'h5, 4'h2, 2'h0, 3'h1);
    t_sel(8'h1e, 4'h8, 4'h9, 2'h0, 3'h1);
    t_sel(8'h1f, 4'h9, 4'h9, 2'h0, 3'h1);
  endtask : t_mux
  task automatic t_hold_lock();
    wr(8'h07, 8'h00);
    run_conv(8'hd1, 26);
    wr(8'h06, 8'hd1);
    wr(8'h07, 8'h4d);
    chk(pos_src_o, 4'h0);
    chk(ref_supply_o, 1'b0);
    wait_conv(24);
    run_conv(8'hd1, 26);
    chk(pos_src_o, 4'h3);
    chk(ref_supply_o, 1'b1);
    // low byte read holds the pair, so the next result must not reach the high byte
    rd(8'h04, lo);
    wr(8'h07, 8'h1f);
    wr(8'h06, 8'hd1);
    wait_conv(26);
    rd(8'h05, hi);
    chk({hi, lo}, {6'h00, 4'h3, 4'h2, 2'h1});
  endtask : t_hold_lock
  task automatic t_abort();
    wr(8'h06, 8'hd1);
    chk(analog_power_o, 1'b1);
    repeat (6) @(posedge clk_i);
    wr(8'h06, 8'h11);
    repeat (2) @(posedge clk_i);
    #1;
    chk(sample_o, 1'b0);
    chk(analog_power_o, 1'b0);
    rd(8'h06, s);
    chk(s[6], 1'b0);
    chk(s[4], 1'b0);
    // enable alone must not start; the later start still pays the first-conversion length
    wr(8'h06, 8'h81);
    chk(sample_o, 1'b0);
    chk(analog_power_o, 1'b1);
    run_conv(8'hd1, 50);
  endtask : t_abort
  task automatic t_free();
    wr(8'h06, 8'hf1);
    repeat (94) @(posedge clk_i);
    #1;
    chk(sample_o, 1'b1);
    rd(8'h06, s);
    chk(s[6], 1'b1);
    chk(s[4], 1'b1);
    wr(8'h06, 8'h91);
    chk(sample_o, 1'b1);
    repeat (30) @(posedge clk_i);
    #1;
    chk(sample_o, 1'b0);
  endtask : t_free
  task automatic t_irq();
    chk(irq_o, 1'b0);
    // whole-register writes with the flag bit zero keep a pending flag
    wr(8'h06, 8'h89);
    chk(irq_o, 1'b0);
    @(posedge clk_i);
    global_irq_en_i <= 1'b1;
    #1;
    chk(irq_o, 1'b1);
    @(posedge clk_i);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    #1;
    chk(irq_o, 1'b0);
    run_conv(8'hc9, 26);
    chk(irq_o, 1'b1);
    wr(8'h06, 8'h99);
    chk(irq_o, 1'b0);
  endtask : t_irq
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_first();
    t_mux();
    t_hold_lock();
    t_abort();
    t_free();
    t_irq();
    tally_and_finish();
  end
  // the whole sequence needs under 6000 clocks
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule : tb_adc_mux_and_control
